/* File: bus_interrupter_module_bench.sv */
// Self-checking bench for the bus interrupter
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module bus_interrupter_module_bench
  import busint_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] irq_in = 4'h0, pend = 4'h0;
  busint_vin_t vin;
  busint_vout_t vout;
  int err_count = 0, tests_run = 0;
  int ctl[4] = '{default:0}, vct[4] = '{default:15};
  logic [31:0] seed = 32'h8F51;

  always #5 pclk = ~pclk;

  busint_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .local_irq_in(irq_in),
    .vin(vin), .vout(vout)
  );
  busint_handler hand (.pclk(pclk), .vout(vout), .vin(vin));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [6:0] exp_irq();
    logic [6:0] q;
    q = 7'h00;
    for (int i = 0; i < 4; i++) begin
      if (pend[i] && ctl[i][4] && (ctl[i] & 7) != 0)
        q[(ctl[i] & 7) - 1] = 1'b1;
    end
    return q;
  endfunction

  task automatic complete_run();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      complete_run();
    end
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e, rl;
    logic [7:0] v;
    logic [1:0] s;
    int k, ek, l, c, m;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, CTRL_BASE + 8'(4 * i), 32'h0, r, e);
      `CHK("ctrl reset", 32'h0, r)
      apb(1'b0, VEC_BASE + 8'(4 * i), 32'h0, r, e);
      `CHK("vector reset", 32'h0F, r)
    end
    apb(1'b0, 8'h30, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e)
    repeat (12) begin
      for (int i = 0; i < 4; i++) begin
        ctl[i] = rnd() & 32'h37;
        vct[i] = rnd() & 32'hFF;
        apb(1'b1, CTRL_BASE + 8'(4 * i), ctl[i], r, e);
        apb(1'b1, VEC_BASE + 8'(4 * i), vct[i], r, e);
        apb(1'b0, CTRL_BASE + 8'(4 * i), 32'h0, r, e);
        `CHK("ctrl readback", ctl[i], r)
      end
      m = rnd() & 15;
      irq_in <= 4'(m);
      repeat (6) @(posedge pclk);
      irq_in <= 4'h0;
      repeat (6) @(posedge pclk);
      pend = pend | 4'(m);
      `CHK("request lines", exp_irq(), vout.irq_oe)
      apb(1'b0, STAT_ADDR, 32'h0, r, e);
      `CHK("pending flags", pend, r[3:0])
      repeat (3) begin
        l = rnd() % 7 + 1;
        c = (rnd() & 7) != 0;
        m = -1;
        for (int i = 3; i >= 0; i--) begin
          if (pend[i] && ctl[i][4] && (ctl[i] & 7) == l) m = i;
        end
        hand.ack(3'(l), c[0], k, v, s, rl);
        ek = !c ? 0 : m < 0 ? 1 : ctl[m][5] ? 3 : 2;
        `CHK("ack response", ek, k)
        if (ek == 2) `CHK("vector", vct[m], v)
        if (ek == 3) `CHK("source code", m, s)
        `CHK("release", 1'b1, rl)
        if (ek > 1) pend[m] = 1'b0;
      end
      `CHK("lines after ack", exp_irq(), vout.irq_oe)
    end
    complete_run();
  end
endmodule

/* File: busint_handler.sv */
// Interrupt handler model that also records the external-mode strobe and source code
`timescale 1ns/1ps
module busint_handler
  import busint_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Bus pins
  input wire busint_vout_t vout,
  output busint_vin_t vin
);
  initial vin = 6'h38;

  // -----------------------------------------------------------------
  // Acknowledge cycle
  // -----------------------------------------------------------------
  task automatic ack(input logic [2:0] l, input logic c, output int k,
                     output logic [7:0] v, output logic [1:0] s,
                     output logic r);
    int n;
    k = 0;
    v = 8'h00;
    s = 2'h0;
    @(posedge pclk);
    vin <= {1'b0, ~c, 1'b1, l};
    for (n = 0; n < 12; n++) begin
      @(posedge pclk);
      if (k == 0 && vout.chain_out_n === 1'b0) k = 1;
      if (k == 0 && vout.dtack_oe === 1'b1) k = vout.data_oe ? 2 : 4;
      if (k == 0 && vout.strobe_n === 1'b0) k = 3;
      if (k == 2) v = vout.data;
      if (k == 3) s = vout.code;
    end
    // Released address lines do not keep the old level
    vin <= {3'b111, ~l};
    repeat (8) @(posedge pclk);
    r = vout.chain_out_n & vout.strobe_n & ~vout.dtack_oe & ~vout.data_oe;
  endtask
endmodule

/* File: busint_pkg.sv */
// Package with constants and carriers for the bus interrupter
// -----------------------------------------------------------------
// Overview of operation
// RULE1: Enable bit four gates each local input
// RULE2: Level field bits zero-two pick request line
// RULE3: Seven open-collector request lines, levels one-seven
// RULE4: Level zero means source is disabled
// RULE5: Shared level held until all sources serviced
// RULE6: Acknowledge start latches direction and level
// RULE7: No chain input means no action
// RULE8: No match passes chain onward
// RULE9: Disabled sources never match acknowledge
// RULE10: Internal mode drives vector then DTACK
// RULE11: Response-select bit chooses internal or external
// RULE12: External mode strobes low with source code
// RULE13: Local device completes external acknowledge; the code has no completion input and holds S_EXT until IACK is released
// RULE14: Separate control and vector per source
// RULE15: Lowest-numbered matching source served first
// RULE16: Acknowledge release negates all driven outputs
// -----------------------------------------------------------------
package busint_pkg;
  localparam int NSRC = 4;
  localparam int NLVL = 7;
  localparam int LVL_LSB = 0;
  localparam int LVL_W = 3;
  localparam int EN_BIT = 4;
  localparam int XSEL_BIT = 5;
  localparam logic [7:0] CTRL_BASE = 8'h00;
  localparam logic [7:0] VEC_BASE = 8'h10;
  localparam logic [7:0] STAT_ADDR = 8'h20;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h0F;
  localparam int ST_PEND_LSB = 0;
  localparam int ST_IRQ_LSB = 4;
  localparam int ST_BUSY_BIT = 11;

  typedef struct packed {
    logic iack_n;
    logic chain_in_n;
    logic write_n;
    logic [2:0] addr;
  } busint_vin_t;

  typedef struct packed {
    logic [NLVL-1:0] irq_oe;
    logic chain_out_n;
    logic dtack_oe;
    logic data_oe;
    logic [7:0] data;
    logic strobe_n;
    logic [1:0] code;
  } busint_vout_t;

  typedef enum logic [2:0] {
    S_IDLE, S_CMP, S_PASS, S_VECT, S_DTACK, S_EXT, S_HOLD
  } busint_state_t;
endpackage

/* File: busint_top.sv */
// Bus interrupter: APB registers, request lines and acknowledge logic
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module busint_top
  import busint_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Local sources
  input wire logic [NSRC-1:0] local_irq_in,
  // System bus pins
  input wire busint_vin_t vin,
  output busint_vout_t vout
);

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  busint_vin_t vin_s1_r;
  busint_vin_t vin_s2_r;
  logic [NSRC-1:0] irq_s1_r;
  logic [NSRC-1:0] irq_s2_r;
  logic [NSRC-1:0] irq_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_s1_r <= '{iack_n: 1'b1, chain_in_n: 1'b1, write_n: 1'b1,
                    addr: 3'h0};
      vin_s2_r <= '{iack_n: 1'b1, chain_in_n: 1'b1, write_n: 1'b1,
                    addr: 3'h0};
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      irq_d_r <= '0;
    end else begin
      vin_s1_r <= vin;
      vin_s2_r <= vin_s1_r;
      irq_s1_r <= local_irq_in;
      irq_s2_r <= irq_s1_r;
      irq_d_r <= irq_s2_r;
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0] ctrl_r [NSRC];
  logic [7:0] vec_r [NSRC];
  logic [NSRC-1:0] pend_r;
  logic [NSRC-1:0] clr_vec;
  busint_state_t state_r;
  logic [LVL_W-1:0] cap_lvl_r;
  logic cap_wr_n_r;
  logic [NLVL-1:0] req_lvl;
  logic found;
  logic [1:0] hit_idx;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [31:0] rdata_nxt;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready;

  always_comb begin
    mapped = (paddr == STAT_ADDR);
    for (int i = 0; i < NSRC; i++) begin
      if (paddr == CTRL_BASE + 8'(4 * i) || paddr == VEC_BASE + 8'(4 * i))
        mapped = 1'b1;
    end
  end

  // RULE14: per-source register pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSRC; i++) begin
        ctrl_r[i] <= CTRL_RST;
        vec_r[i] <= VEC_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NSRC; i++) begin
        if (paddr == CTRL_BASE + 8'(4 * i))
          ctrl_r[i] <= pwdata[7:0];
        if (paddr == VEC_BASE + 8'(4 * i))
          vec_r[i] <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < NSRC; i++) begin
      if (paddr == CTRL_BASE + 8'(4 * i))
        rdata_nxt = {24'h000000, ctrl_r[i]};
      if (paddr == VEC_BASE + 8'(4 * i))
        rdata_nxt = {24'h000000, vec_r[i]};
    end
    if (paddr == STAT_ADDR) begin
      rdata_nxt[ST_PEND_LSB +: NSRC] = pend_r;
      rdata_nxt[ST_IRQ_LSB +: NLVL] = vout.irq_oe;
      rdata_nxt[ST_BUSY_BIT] = (state_r != S_IDLE);
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_en;
      pslverr <= rd_en && !mapped;
      if (rd_en && !pwrite)
        prdata <= rdata_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Pending flags and request lines
  // -----------------------------------------------------------------
  function automatic logic qual(input logic [7:0] c, input logic p);
    // RULE1: enable gates the input
    // RULE4: level zero drives nothing
    qual = c[EN_BIT] && p && (c[LVL_LSB +: LVL_W] != 3'h0);
  endfunction

  // RULE5: flag cleared only by its own acknowledge, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pend_r <= '0;
    else
      pend_r <= (pend_r & ~clr_vec) | (irq_s2_r & ~irq_d_r);
  end

  always_comb begin
    req_lvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      // RULE2: level field selects the line
      if (qual(ctrl_r[i], pend_r[i]))
        req_lvl[ctrl_r[i][LVL_LSB +: LVL_W] - 3'h1] = 1'b1;
    end
  end

  // RULE3: open-collector enables, one per level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      vout.irq_oe <= '0;
    else
      vout.irq_oe <= req_lvl;
  end

  // -----------------------------------------------------------------
  // Acknowledge match
  // -----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    hit_idx = 2'h0;
    // RULE15: lowest index wins
    for (int i = NSRC - 1; i >= 0; i--) begin
      // RULE9: disabled sources excluded
      if (qual(ctrl_r[i], pend_r[i]) &&
          ctrl_r[i][LVL_LSB +: LVL_W] == cap_lvl_r) begin
        found = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end

  always_comb begin
    clr_vec = '0;
    if (state_r == S_CMP && !vin_s2_r.iack_n && !vin_s2_r.chain_in_n &&
        found)
      clr_vec[hit_idx] = 1'b1;
  end

  // -----------------------------------------------------------------
  // Acknowledge sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      cap_lvl_r <= 3'h0;
      cap_wr_n_r <= 1'b1;
      vout.chain_out_n <= 1'b1;
      vout.dtack_oe <= 1'b0;
      vout.data_oe <= 1'b0;
      vout.data <= 8'h00;
      vout.strobe_n <= 1'b1;
      vout.code <= 2'h0;
    end else if (vin_s2_r.iack_n) begin
      // RULE7: no chain input, cycle ends quietly
      // RULE16: release everything at end of cycle
      state_r <= S_IDLE;
      vout.chain_out_n <= 1'b1;
      vout.dtack_oe <= 1'b0;
      vout.data_oe <= 1'b0;
      vout.strobe_n <= 1'b1;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          // RULE6: latch direction and level
          cap_lvl_r <= vin_s2_r.addr;
          cap_wr_n_r <= vin_s2_r.write_n;
          state_r <= S_CMP;
        end
        S_CMP: begin
          if (!vin_s2_r.chain_in_n) begin
            if (!found) begin
              // RULE8: pass the chain on
              vout.chain_out_n <= 1'b0;
              state_r <= S_PASS;
            end else if (!ctrl_r[hit_idx][XSEL_BIT]) begin
              // RULE11: select bit clear, internal vector
              vout.data <= vec_r[hit_idx];
              vout.data_oe <= 1'b1;
              state_r <= S_VECT;
            end else begin
              // RULE12: external completion
              vout.strobe_n <= 1'b0;
              vout.code <= hit_idx;
              state_r <= S_EXT;
            end
          end
        end
        S_VECT: begin
          // RULE10: DTACK after vector
          vout.dtack_oe <= 1'b1;
          state_r <= S_DTACK;
        end
        S_PASS, S_DTACK, S_EXT, S_HOLD: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [NSRC-1:0] en_pend;
  always_comb begin
    for (int i = 0; i < NSRC; i++)
      en_pend[i] = qual(ctrl_r[i], pend_r[i]);
  end

  logic [NSRC-1:0] lvl_match;
  always_comb begin
    for (int i = 0; i < NSRC; i++)
      lvl_match[i] = en_pend[i] && ctrl_r[i][LVL_LSB +: LVL_W] == cap_lvl_r;
  end

  sequence ack_start;
    state_r == S_IDLE && !vin_s2_r.iack_n;
  endsequence

  sequence chain_seen;
    state_r == S_CMP && !vin_s2_r.iack_n && !vin_s2_r.chain_in_n;
  endsequence

  a_irq_gated: assert property ( // RULE1
    |vout.irq_oe |-> $past(|(pend_r & en_pend)))
    else $error("request line without enabled source");

  a_irq_level: assert property ( // RULE2
    en_pend[0] |=> vout.irq_oe[$past(ctrl_r[0][LVL_LSB +: LVL_W]) - 3'h1])
    else $error("source 0 not on its level line");

  a_irq_none: assert property ( // RULE4
    en_pend == '0 |=> vout.irq_oe == '0)
    else $error("request line with no qualifying source");

  a_pend_clear: assert property ( // RULE5
    ((~pend_r & $past(pend_r)) & ~$past(clr_vec)) == '0)
    else $error("pending flag lost without acknowledge");

  a_ack_latch: assert property ( // RULE6
    ack_start |=> state_r == S_CMP && cap_lvl_r == $past(vin_s2_r.addr) &&
      cap_wr_n_r == $past(vin_s2_r.write_n))
    else $error("acknowledge level not latched");

  a_no_chain: assert property ( // RULE7
    state_r == S_CMP && vin_s2_r.chain_in_n |=>
      vout.chain_out_n && !vout.data_oe && vout.strobe_n)
    else $error("action without chain input");

  a_chain_pass: assert property ( // RULE8
    chain_seen ##0 !found |=> !vout.chain_out_n)
    else $error("chain not passed on");

  a_match_enabled: assert property ( // RULE9
    chain_seen ##0 found |-> ctrl_r[hit_idx][EN_BIT])
    else $error("disabled source matched");

  a_vect_dtack: assert property ( // RULE10
    chain_seen ##0 found ##0 !ctrl_r[hit_idx][XSEL_BIT] ##1
      !vin_s2_r.iack_n |=> vout.data_oe && vout.dtack_oe)
    else $error("vector then DTACK missing");

  a_ext_strobe: assert property ( // RULE12
    state_r == S_EXT && !vin_s2_r.iack_n |-> !vout.strobe_n &&
      vout.chain_out_n && !vout.dtack_oe)
    else $error("external mode outputs wrong");

  a_release: assert property ( // RULE16
    vin_s2_r.iack_n |=> vout.chain_out_n && vout.strobe_n &&
      !vout.dtack_oe && !vout.data_oe && state_r == S_IDLE)
    else $error("outputs not released");

  a_line_follow: assert property ( // RULE3
    vout.irq_oe == $past(req_lvl))
    else $error("request lines do not follow requests");

  a_reg_own: assert property ( // RULE14
    wr_en && paddr == CTRL_BASE |=> ctrl_r[0] == $past(pwdata[7:0]) &&
      $stable(vec_r[0]) && $stable(ctrl_r[1]))
    else $error("control write leaked to another register");

  a_low_first: assert property ( // RULE15
    chain_seen ##0 found |-> lvl_match[hit_idx] &&
      (lvl_match & ((4'h1 << hit_idx) - 4'h1)) == 4'h0)
    else $error("higher source served before lower one");

  a_vect_value: assert property ( // RULE10
    chain_seen ##0 found ##0 !ctrl_r[hit_idx][XSEL_BIT] |=>
      vout.data_oe && vout.data == $past(vec_r[hit_idx]) && vout.chain_out_n)
    else $error("wrong vector supplied");

  a_ext_select: assert property ( // RULE11
    chain_seen ##0 found ##0 ctrl_r[hit_idx][XSEL_BIT] |=> !vout.strobe_n &&
      vout.code == $past(hit_idx) && !vout.data_oe && vout.chain_out_n)
    else $error("external response not selected");

endmodule
